// ### logic/ovm_defines.vh
// Register map, field positions and reset values of the VBUS monitor
`ifndef OVM_DEFINES_VH
`define OVM_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OVM_REG_CMP_STATUS 8'h00
`define OVM_REG_IE_RISE 8'h04
`define OVM_REG_IE_FALL 8'h08
`define OVM_REG_OTG_CTRL 8'h0c
`define OVM_REG_EXT_IND 8'h10
`define OVM_REG_EVT_STATUS 8'h14
`define OVM_REG_EVT_MASK 8'h18

// ****************************************************************
// Field positions
// ****************************************************************
// Comparator fields sit in bits 3..1 of status, enable and event regs
`define OVM_CMP_LSB 1
`define OVM_CMP_MSB 3
// Channel index inside the three-bit comparator vectors
`define OVM_CH_BUSV 0
`define OVM_CH_SESSV 1
`define OVM_CH_SESSION_END_CMP 2
`define OVM_NUM_CH 3
`define OVM_OTG_PULLDOWN 3
`define OVM_OTG_PULLUP 4
`define OVM_EXT_SELECT 0
`define OVM_EXT_PASS 1
`define OVM_EXT_COMPL 2

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define OVM_IE_RST 3'h7
`define OVM_CH_ZERO 3'h0
`define OVM_OTG_RST 2'h0
`define OVM_EXT_RST 3'h0
`define OVM_WORD_ZERO 32'h0000_0000
`define OVM_EXT_IND_LEVEL 1'b1
`define OVM_HTRANS_NONSEQ_BIT 1

`endif

// ### logic/ovm_cmp_chan.v
// One VBUS comparator channel: enable gating and edge events
`timescale 1ns/1ns
module ovm_cmp_chan #(
    parameter KEEP_RUNNING = 0
)(
    input wire hclk,
    input wire hresetn,
    input wire cmp_in,
    input wire rise_en,
    input wire fall_en,
    output wire status,
    output wire rise_evt,
    output wire fall_evt,
    output wire toggled
);

    reg cmp_ff;
    wire enabled;

    // ****************************************************************
    // Enable and status
    // ****************************************************************
    // Either enable keeps the comparator alive
    assign enabled = rise_en | fall_en;
    // A switched-off comparator reads zero unless it must keep running
    assign status = (enabled || KEEP_RUNNING != 0) ? cmp_ff : 1'b0;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cmp_ff <= 1'b0;
        else
            cmp_ff <= cmp_in;
    end

    // ****************************************************************
    // Edge events
    // ****************************************************************
    assign rise_evt = rise_en & cmp_in & ~cmp_ff;
    assign fall_evt = fall_en & ~cmp_in & cmp_ff;
    // Raw change, independent of the interrupt enables
    assign toggled = cmp_in ^ cmp_ff;

endmodule

// ### logic/ovm_vbus_monitor.v
// VBUS monitor and pulsing control with AHB-Lite register access
//
// Notes on behaviour
// - Status register shows bus-valid, session-valid and session-end levels.
// - Session-end reads 1 once VBUS drops below its end threshold.
// - Session-end with both edge enables cleared is off and reads 0.
// - Every session-valid change raises a receive command to the link.
// - Session-valid enables gate only interrupts; receive commands continue.
// - Bus-valid with both edge enables cleared is off; status bit 1 is 0.
// - External indicator is a constant one; selection off after reset.
// - Selection 0: receive command bus-valid comes from the comparator.
// - Selection 1: complement gives 0, pass-through 1, else comparator.
// - Control bit 3 drives the VBUS pull-down for discharging.
// - Control bit 4 drives the VBUS pull-up for session request pulses.
`timescale 1ns/1ns
`include "ovm_defines.vh"
module ovm_vbus_monitor #(
    parameter AW = 8
)(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [AW-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    input wire bus_valid_cmp,
    input wire session_valid_cmp,
    input wire session_end_cmp,
    output wire vbus_pulldown_ctl,
    output wire vbus_pullup_ctl,
    output wire rxcmd_valid,
    input wire rxcmd_ready,
    output wire rxcmd_bus_valid,
    output wire rxcmd_sess_valid,
    output wire rxcmd_sess_end,
    output wire irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg [2:0] ie_rise_ff;
    reg [2:0] ie_fall_ff;
    reg [1:0] otg_ctl_ff;
    reg [2:0] ext_ind_ff;
    reg [2:0] evt_ff;
    reg [2:0] evt_mask_ff;
    reg [2:0] nxt_evt;
    reg wr_pend_ff;
    reg rd_wait_ff;
    reg [AW-1:0] addr_ff;
    reg [31:0] hrdata_ff;
    reg [31:0] rd_mux;
    reg rxcmd_valid_ff;
    reg rxcmd_busv_ff;
    reg rxcmd_sessv_ff;
    reg rxcmd_send_ff;
    reg rxcmd_busv_src_ff;
    wire [2:0] cmp_raw;
    wire [2:0] cmp_status;
    wire [2:0] rise_evt;
    wire [2:0] fall_evt;
    wire [2:0] toggled;
    wire [2:0] evt_set;
    wire [2:0] evt_clr;
    wire addr_take;
    wire wr_hit;
    wire busv_src;
    wire rxcmd_change;

    assign cmp_raw[`OVM_CH_BUSV] = bus_valid_cmp;
    assign cmp_raw[`OVM_CH_SESSV] = session_valid_cmp;
    assign cmp_raw[`OVM_CH_SESSION_END_CMP] = session_end_cmp;

    // ****************************************************************
    // Comparator channels
    // ****************************************************************
    // Only session-valid stays running with its enables cleared
    genvar gi;
    generate
        for (gi = 0; gi < `OVM_NUM_CH; gi = gi + 1)
        begin : g_chan
            ovm_cmp_chan #(
                .KEEP_RUNNING(gi == `OVM_CH_SESSV)
            ) u_chan (
                .hclk(hclk),
                .hresetn(hresetn),
                .cmp_in(cmp_raw[gi]),
                .rise_en(ie_rise_ff[gi]),
                .fall_en(ie_fall_ff[gi]),
                .status(cmp_status[gi]),
                .rise_evt(rise_evt[gi]),
                .fall_evt(fall_evt[gi]),
                .toggled(toggled[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // AHB-Lite address and data phase
    // ****************************************************************
    // Writes finish with no wait state. Reads take one wait state so
    // that a read right behind a write sees the freshly written value.
    assign addr_take = hsel & htrans[`OVM_HTRANS_NONSEQ_BIT] & hready;
    assign wr_hit = wr_pend_ff;
    assign hreadyout = ~rd_wait_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            rd_wait_ff <= 1'b0;
            addr_ff <= {AW{1'b0}};
        end
        else
        begin
            wr_pend_ff <= addr_take & hwrite;
            rd_wait_ff <= addr_take & ~hwrite;
            if (addr_take)
                addr_ff <= haddr;
        end
    end

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    always @*
    begin
        rd_mux = `OVM_WORD_ZERO;
        case (addr_ff)
            `OVM_REG_CMP_STATUS:
                rd_mux[`OVM_CMP_MSB:`OVM_CMP_LSB] = cmp_status;
            `OVM_REG_IE_RISE:
                rd_mux[`OVM_CMP_MSB:`OVM_CMP_LSB] = ie_rise_ff;
            `OVM_REG_IE_FALL:
                rd_mux[`OVM_CMP_MSB:`OVM_CMP_LSB] = ie_fall_ff;
            `OVM_REG_OTG_CTRL:
            begin
                rd_mux[`OVM_OTG_PULLDOWN] = otg_ctl_ff[0];
                rd_mux[`OVM_OTG_PULLUP] = otg_ctl_ff[1];
            end
            `OVM_REG_EXT_IND:
                rd_mux[`OVM_EXT_COMPL:`OVM_EXT_SELECT] = ext_ind_ff;
            `OVM_REG_EVT_STATUS:
                rd_mux[`OVM_CMP_MSB:`OVM_CMP_LSB] = evt_ff;
            `OVM_REG_EVT_MASK:
                rd_mux[`OVM_CMP_MSB:`OVM_CMP_LSB] = evt_mask_ff;
            default:
                rd_mux = `OVM_WORD_ZERO;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_ff <= `OVM_WORD_ZERO;
        else if (rd_wait_ff)
            hrdata_ff <= rd_mux;
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Enables come up set so every comparator is live after reset
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ie_rise_ff <= `OVM_IE_RST;
            ie_fall_ff <= `OVM_IE_RST;
            otg_ctl_ff <= `OVM_OTG_RST;
            ext_ind_ff <= `OVM_EXT_RST;
            evt_mask_ff <= `OVM_CH_ZERO;
        end
        else if (wr_hit)
        begin
            case (addr_ff)
                `OVM_REG_IE_RISE:
                    ie_rise_ff <= hwdata[`OVM_CMP_MSB:`OVM_CMP_LSB];
                `OVM_REG_IE_FALL:
                    ie_fall_ff <= hwdata[`OVM_CMP_MSB:`OVM_CMP_LSB];
                `OVM_REG_OTG_CTRL:
                    otg_ctl_ff <= {hwdata[`OVM_OTG_PULLUP],
                        hwdata[`OVM_OTG_PULLDOWN]};
                `OVM_REG_EXT_IND:
                    ext_ind_ff <= hwdata[`OVM_EXT_COMPL:`OVM_EXT_SELECT];
                `OVM_REG_EVT_MASK:
                    evt_mask_ff <= hwdata[`OVM_CMP_MSB:`OVM_CMP_LSB];
                default:
                    evt_mask_ff <= evt_mask_ff;
            endcase
        end
    end

    // ****************************************************************
    // Pulsing resistor controls
    // ****************************************************************
    // Both may be set at once; software keeps them exclusive
    assign vbus_pulldown_ctl = otg_ctl_ff[0];
    assign vbus_pullup_ctl = otg_ctl_ff[1];

    // ****************************************************************
    // Interrupt events
    // ****************************************************************
    // Edge events of disabled comparators never reach the sticky bits
    assign evt_set = rise_evt | fall_evt;
    assign evt_clr = (wr_hit && addr_ff == `OVM_REG_EVT_STATUS) ?
        hwdata[`OVM_CMP_MSB:`OVM_CMP_LSB] : `OVM_CH_ZERO;

    always @*
    begin
        // A new event in the clearing cycle survives the clear
        nxt_evt = (evt_ff & ~evt_clr) | evt_set;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            evt_ff <= `OVM_CH_ZERO;
        else
            evt_ff <= nxt_evt;
    end

    assign irq = |(evt_ff & evt_mask_ff);

    // ****************************************************************
    // Receive command bus-valid source
    // ****************************************************************
    // The external indicator is fixed high, so pass-through forces one
    assign busv_src = !ext_ind_ff[`OVM_EXT_SELECT] ?
        cmp_status[`OVM_CH_BUSV] :
        ext_ind_ff[`OVM_EXT_COMPL] ? 1'b0 :
        ext_ind_ff[`OVM_EXT_PASS] ? `OVM_EXT_IND_LEVEL :
        cmp_status[`OVM_CH_BUSV];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rxcmd_busv_src_ff <= 1'b0;
        else
            rxcmd_busv_src_ff <= busv_src;
    end

    // ****************************************************************
    // Receive command generation
    // ****************************************************************
    // Session-valid toggles raise a command whatever its enables say.
    // Only the latest state is kept: changes while one waits merge.
    assign rxcmd_change = toggled[`OVM_CH_SESSV] |
        (busv_src ^ rxcmd_busv_src_ff) |
        toggled[`OVM_CH_SESSION_END_CMP];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rxcmd_valid_ff <= 1'b0;
            rxcmd_busv_ff <= 1'b0;
            rxcmd_sessv_ff <= 1'b0;
            rxcmd_send_ff <= 1'b0;
        end
        else
        begin
            if (rxcmd_change)
                rxcmd_valid_ff <= 1'b1;
            else if (rxcmd_ready)
                rxcmd_valid_ff <= 1'b0;
            rxcmd_busv_ff <= busv_src;
            rxcmd_sessv_ff <= session_valid_cmp;
            // Taken from the pin so the command that announces a
            // session-end change already carries the new level
            rxcmd_send_ff <= session_end_cmp;
        end
    end

    assign rxcmd_valid = rxcmd_valid_ff;
    assign rxcmd_bus_valid = rxcmd_busv_ff;
    assign rxcmd_sess_valid = rxcmd_sessv_ff;
    assign rxcmd_sess_end = rxcmd_send_ff;

endmodule

// ### test/ovm_asserts.sv
// Port checker for the VBUS monitor
`timescale 1ns/1ns
`include "ovm_defines.vh"
module ovm_asserts #(
    parameter AW = 8
)(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [AW-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire bus_valid_cmp,
    input wire session_valid_cmp,
    input wire session_end_cmp,
    input wire vbus_pulldown_ctl,
    input wire vbus_pullup_ctl,
    input wire rxcmd_valid,
    input wire rxcmd_ready,
    input wire rxcmd_bus_valid,
    input wire rxcmd_sess_valid,
    input wire rxcmd_sess_end,
    input wire irq
);
// ******
// Helpers
// ******
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
wire addr_req = hsel && htrans[1] && hready;
logic wr_otg_ff;
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
        wr_otg_ff <= 1'h0;
    else if (hready)
        wr_otg_ff <= addr_req && hwrite && haddr == `OVM_REG_OTG_CTRL;
end
property p_rd_wait;
    addr_req && !hwrite |=> !hreadyout ##1 hreadyout;
endproperty
a_rd_wait: assert property (p_rd_wait) else $error("read wait");
property p_wr_zero;
    addr_req && hwrite |=> hreadyout;
endproperty
a_wr_zero: assert property (p_wr_zero) else $error("write wait");
property p_pulldown;
    wr_otg_ff && hreadyout |=> vbus_pulldown_ctl == $past(hwdata[3]);
endproperty
a_pulldown: assert property (p_pulldown) else $error("pulldown");
property p_pullup;
    wr_otg_ff && hreadyout |=> vbus_pullup_ctl == $past(hwdata[4]);
endproperty
a_pullup: assert property (p_pullup) else $error("pullup");
property p_sv_cmd;
    $changed(session_valid_cmp) |=>
        rxcmd_valid && rxcmd_sess_valid == $past(session_valid_cmp);
endproperty
a_sv_cmd: assert property (p_sv_cmd) else $error("sv cmd");
property p_se_cmd;
    $changed(session_end_cmp) |=>
        rxcmd_valid && rxcmd_sess_end == $past(session_end_cmp);
endproperty
a_se_cmd: assert property (p_se_cmd) else $error("se cmd");
property p_hold;
    rxcmd_valid && !rxcmd_ready |=> rxcmd_valid;
endproperty
a_hold: assert property (p_hold) else $error("cmd dropped");
property p_rst;
    $rose(hresetn) |-> !vbus_pulldown_ctl && !vbus_pullup_ctl;
endproperty
a_rst: assert property (p_rst) else $error("pulls at reset");
c_cmd: cover property (rxcmd_valid && rxcmd_ready);
c_irq: cover property ($rose(irq));
c_rd: cover property (addr_req && !hwrite);
endmodule
bind ovm_vbus_monitor ovm_asserts #(.AW(AW)) ovm_asserts_inst (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .bus_valid_cmp, .session_valid_cmp,
    .session_end_cmp, .vbus_pulldown_ctl, .vbus_pullup_ctl, .rxcmd_valid,
    .rxcmd_ready, .rxcmd_bus_valid, .rxcmd_sess_valid, .rxcmd_sess_end,
    .irq);

// ### test/ovm_link_model.sv
// Link-side model that takes receive commands
`timescale 1ns/1ns
module ovm_link_model (
    input wire hclk,
    input wire hresetn,
    input wire slow,
    input wire rxcmd_valid,
    input wire rxcmd_sess_valid,
    output logic rxcmd_ready,
    output logic vbus_seen
);
logic [1:0] cnt_ff;
// Slow mode takes one command in four cycles to stretch pending ones
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        cnt_ff <= 2'h0;
        rxcmd_ready <= 1'h0;
        vbus_seen <= 1'h0;
    end
    else
    begin
        cnt_ff <= cnt_ff + 2'h1;
        rxcmd_ready <= !slow || cnt_ff == 2'h3;
        if (rxcmd_valid && rxcmd_ready)
            vbus_seen <= rxcmd_sess_valid;
    end
end
endmodule

// ### test/testbench.sv
// Self-checking bench of the VBUS monitor
`timescale 1ns/1ns
`include "ovm_defines.vh"
module testbench;
logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0;
logic [7:0] haddr = 0;
logic [1:0] htrans = 0;
logic [2:0] hsize = 3'h2;
logic [31:0] hwdata = 0, rd;
logic bus_valid_cmp = 0, session_valid_cmp = 0, session_end_cmp = 0;
wire hready, hreadyout, hresp, vbus_pulldown_ctl, vbus_pullup_ctl, irq;
wire rxcmd_valid, rxcmd_ready, rxcmd_bus_valid, rxcmd_sess_valid;
wire rxcmd_sess_end, vbus_seen;
wire [31:0] hrdata;
integer err_count = 0, compares = 0, i;
assign hready = hreadyout;
ovm_vbus_monitor #(.AW(8)) ovm_vbus_monitor_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .bus_valid_cmp, .session_valid_cmp, .session_end_cmp,
    .vbus_pulldown_ctl, .vbus_pullup_ctl, .rxcmd_valid, .rxcmd_ready,
    .rxcmd_bus_valid, .rxcmd_sess_valid, .rxcmd_sess_end, .irq);
ovm_link_model ovm_link_model_inst (.hclk, .hresetn, .slow, .rxcmd_valid,
    .rxcmd_sess_valid, .rxcmd_ready, .vbus_seen);
initial forever #5 hclk = ~hclk;
// ******
// Shared tasks
// ******
task report_and_stop;
begin
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
end
endtask
task check(input string what, input logic [31:0] seen, exp);
begin
    compares = compares + 1;
    if (seen !== exp)
    begin
        err_count = err_count + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
    end
end
endtask
// Every wait is bounded so a hung handshake ends the run
task guard(inout integer n);
begin
    n = n + 1;
    if (n > 60)
    begin
        err_count = err_count + 1;
        report_and_stop;
    end
    else
        @(posedge hclk);
end
endtask
task xfer(input [7:0] a, input w, input [31:0] wd);
    integer n;
begin
    n = 0;
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    guard(n);
    while (hready !== 1'h1) guard(n);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    guard(n);
    while (hready !== 1'h1) guard(n);
    rd = hrdata;
end
endtask
task wait_cmd(input logic v);
    integer n;
begin
    n = 0;
    while (rxcmd_valid !== v) guard(n);
end
endtask
// ******
// Scenarios
// ******
task t_reset;
begin
    check("pulls", {vbus_pullup_ctl, vbus_pulldown_ctl}, 0);
    check("hresp", hresp, 0);
    xfer(`OVM_REG_EXT_IND, 0, 0);
    check("ext", rd, 0);
    xfer(`OVM_REG_IE_RISE, 0, 0);
    check("ie_rise", rd, 32'h0000_000e);
    xfer(8'h1c, 0, 0);
    check("unmapped", rd, 0);
    $display("reset test done");
end
endtask
task t_status;
begin
    for (i = 0; i < 8; i = i + 1)
    begin
        {session_end_cmp, session_valid_cmp, bus_valid_cmp} <= i[2:0];
        repeat (2) @(posedge hclk);
        xfer(`OVM_REG_CMP_STATUS, 0, 0);
        check("status", rd, {i[2:0], 1'h0});
    end
    xfer(`OVM_REG_IE_RISE, 1, 0);
    xfer(`OVM_REG_IE_FALL, 1, 0);
    xfer(`OVM_REG_CMP_STATUS, 0, 0);
    check("status off", rd, 32'h0000_0004);
    xfer(`OVM_REG_IE_FALL, 1, 32'h0000_000a);
    xfer(`OVM_REG_CMP_STATUS, 0, 0);
    check("status one edge", rd, 32'h0000_000e);
    $display("status test done");
end
endtask
task t_rxcmd;
begin
    slow <= 1'h1;
    xfer(`OVM_REG_EVT_STATUS, 1, 32'h0000_000e);
    for (i = 0; i < 2; i = i + 1)
    begin
        session_valid_cmp <= i[0];
        wait_cmd(1'h1);
        check("cmd sv", rxcmd_sess_valid, i[0]);
        wait_cmd(1'h0);
        check("link vbus", vbus_seen, i[0]);
    end
    xfer(`OVM_REG_EVT_STATUS, 0, 0);
    check("sv event", rd[2], 0);
    slow <= 1'h0;
    $display("rxcmd test done");
end
endtask
task t_ext;
begin
    xfer(`OVM_REG_IE_RISE, 1, 32'h0000_000e);
    xfer(`OVM_REG_IE_FALL, 1, 32'h0000_000e);
    for (i = 0; i < 16; i = i + 1)
    begin
        xfer(`OVM_REG_EXT_IND, 1, i[2:0]);
        bus_valid_cmp <= i[3];
        repeat (3) @(posedge hclk);
        check("cmd bv", rxcmd_bus_valid, !i[0] ? i[3] : i[2] ? 0 :
            i[1] ? 1 : i[3]);
    end
    xfer(`OVM_REG_EXT_IND, 1, 0);
    $display("ext test done");
end
endtask
task t_pulse;
begin
    for (i = 0; i < 4; i = i + 1)
    begin
        xfer(`OVM_REG_OTG_CTRL, 1, {i[1:0], 3'h0});
        @(posedge hclk);
        check("pulls", {vbus_pullup_ctl, vbus_pulldown_ctl},
            i[1:0]);
    end
    $display("pulse test done");
end
endtask
task t_irq;
begin
    xfer(`OVM_REG_EVT_MASK, 1, 32'h0000_0008);
    xfer(`OVM_REG_EVT_STATUS, 1, 32'h0000_000e);
    session_end_cmp <= ~session_end_cmp;
    repeat (3) @(posedge hclk);
    check("irq", irq, 1);
    check("cmd se", rxcmd_sess_end, session_end_cmp);
    xfer(`OVM_REG_EVT_STATUS, 0, 0);
    check("se event", rd[3], 1);
    xfer(`OVM_REG_EVT_STATUS, 1, 32'h0000_0008);
    @(posedge hclk);
    check("irq clear", irq, 0);
    xfer(`OVM_REG_EVT_MASK, 1, 0);
    session_end_cmp <= ~session_end_cmp;
    repeat (3) @(posedge hclk);
    check("irq masked", irq, 0);
    $display("irq test done");
end
endtask
initial
begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset;
    t_status;
    t_rxcmd;
    t_ext;
    t_pulse;
    t_irq;
    report_and_stop;
end
endmodule
